/* design/idte_engine.sv */
// Local design decisions: the register offsets and the strobed register port.
module idte_engine #(
    parameter int NUM_SRC = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] act_req,
    output logic [NUM_SRC-1:0] act_ack,
    output logic [NUM_SRC-1:0] src_irq_pass,
    output logic software_transfer_end_irq,
    output idte_pkg::idte_mem_req_t mem_out,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);
    import idte_pkg::*;

    localparam int SRC_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

    initial
    begin
        if (NUM_SRC < 1 || NUM_SRC > 8)
            $error("NUM_SRC must lie between 1 and 8");
    end

    typedef struct packed {
        idte_state_t st;
        logic sw;
        logic [SRC_W-1:0] src;
        logic [23:0] desc;
        logic [7:0] mwa;
        logic [7:0] mwb;
        logic [23:0] srca;
        logic [23:0] dsta;
        logic [23:0] area0;
        logic [15:0] cnta;
        logic [15:0] cntb;
        logic [15:0] data;
        logic done;
        idte_mem_req_t mem;
        logic [6:0] vec;
        logic swflag;
        logic swend;
        logic [NUM_SRC-1:0] en;
        logic [7:0] rdata;
        logic [NUM_SRC-1:0] ack;
        logic [NUM_SRC-1:0] pass;
    } idte_regs_t;

    idte_regs_t s_ff;
    idte_regs_t nxt_s;

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] m, input logic sz);
        logic [23:0] d;
        d = sz ? 24'h000002 : 24'h000001;
        if (m == AM_INC)
            step_addr = a + d;
        else if (m == AM_DEC)
            step_addr = a - d;
        else
            step_addr = a;
    endfunction

    function automatic logic [23:0] vec_addr(input logic [6:0] v);
        vec_addr = VEC_BASE + {16'h0000, v, 1'b0};
    endfunction

    logic hw_hit;
    logic [SRC_W-1:0] hw_src;

    // Lowest index wins; software outranks every source
    always_comb
    begin
        hw_hit = 1'b0;
        hw_src = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (act_req[i] && s_ff.en[i])
            begin
                hw_hit = 1'b1;
                hw_src = SRC_W'(i);
            end
        end
    end

    logic [1:0] md;
    logic sz;
    logic area_src;
    logic chain;
    logic fire;
    logic [23:0] srca_n;
    logic [23:0] dsta_n;
    logic [7:0] cntl_n;
    logic [15:0] cntb_n;

    assign md = s_ff.mwa[MA_MD_HI:MA_MD_LO];
    assign sz = s_ff.mwa[MA_SZ];
    assign area_src = s_ff.mwa[MA_AREA];
    assign chain = s_ff.mwb[MB_CHAIN];
    assign fire = s_ff.done || s_ff.mwb[MB_IRQSEL];
    assign srca_n = step_addr(s_ff.srca, s_ff.mwa[MA_SM_HI:MA_SM_LO], sz);
    assign dsta_n = step_addr(s_ff.dsta, s_ff.mwa[MA_DM_HI:MA_DM_LO], sz);
    assign cntl_n = s_ff.cnta[7:0] - 8'h01;
    assign cntb_n = s_ff.cntb - 16'h0001;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.ack = '0;
        nxt_s.pass = '0;
        nxt_s.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                REG_SWVEC: nxt_s.rdata = {s_ff.swflag, s_ff.vec};
                REG_ENABLE: nxt_s.rdata = 8'(s_ff.en);
                REG_STATUS: nxt_s.rdata = {6'h00, s_ff.swend, s_ff.st != ST_IDLE};
                default: nxt_s.rdata = 8'h00;
            endcase
        end
        case (s_ff.st)
            ST_IDLE:
            begin
                // Pending end holds off a new software start
                if (s_ff.swflag && !s_ff.swend)
                begin
                    nxt_s.sw = 1'b1;
                    nxt_s.desc = vec_addr(s_ff.vec);
                    nxt_s.st = ST_VEC;
                end
                else if (hw_hit)
                begin
                    nxt_s.sw = 1'b0;
                    nxt_s.src = hw_src;
                    nxt_s.desc = vec_addr(SRC_VEC_FIRST + 7'(hw_src));
                    nxt_s.st = ST_VEC;
                end
            end
            ST_VEC:
            begin
                if (mem_ack)
                begin
                    nxt_s.desc = {DESC_PAGE, mem_rdata[15:2], 2'b00};
                    nxt_s.st = ST_RD0;
                end
            end
            ST_RD0:
            begin
                if (mem_ack)
                begin
                    nxt_s.mwa = mem_rdata[31:24];
                    nxt_s.srca = mem_rdata[23:0];
                    nxt_s.st = ST_RD1;
                end
            end
            ST_RD1:
            begin
                if (mem_ack)
                begin
                    nxt_s.mwb = mem_rdata[31:24];
                    nxt_s.dsta = mem_rdata[23:0];
                    nxt_s.st = ST_RD2;
                end
            end
            ST_RD2:
            begin
                if (mem_ack)
                begin
                    nxt_s.cnta = mem_rdata[31:16];
                    nxt_s.cntb = mem_rdata[15:0];
                    nxt_s.area0 = area_src ? s_ff.srca : s_ff.dsta;
                    nxt_s.done = 1'b0;
                    nxt_s.st = ST_DRD;
                end
            end
            ST_DRD:
            begin
                if (mem_ack)
                begin
                    nxt_s.data = sz ? mem_rdata[15:0] : {8'h00, mem_rdata[7:0]};
                    nxt_s.st = ST_DWR;
                end
            end
            ST_DWR:
            begin
                if (mem_ack)
                begin
                    nxt_s.srca = srca_n;
                    nxt_s.dsta = dsta_n;
                    nxt_s.st = ST_WB0;
                    case (md)
                        MD_REPEAT:
                        begin
                            nxt_s.cnta[7:0] = cntl_n;
                            if (cntl_n == 8'h00)
                            begin
                                // Counter reloads from the high byte and done stays clear, so no completion
                                nxt_s.cnta[7:0] = s_ff.cnta[15:8];
                                if (area_src)
                                    nxt_s.srca = s_ff.area0;
                                else
                                    nxt_s.dsta = s_ff.area0;
                            end
                        end
                        MD_BLOCK:
                        begin
                            nxt_s.cnta[7:0] = cntl_n;
                            if (cntl_n == 8'h00)
                            begin
                                nxt_s.cnta[7:0] = s_ff.cnta[15:8];
                                if (area_src)
                                    nxt_s.srca = s_ff.area0;
                                else
                                    nxt_s.dsta = s_ff.area0;
                                nxt_s.cntb = cntb_n;
                                nxt_s.done = cntb_n == 16'h0000;
                            end
                            else
                                nxt_s.st = ST_DRD;
                        end
                        default:
                        begin
                            nxt_s.cnta = s_ff.cnta - 16'h0001;
                            nxt_s.done = s_ff.cnta == 16'h0001;
                        end
                    endcase
                end
            end
            ST_WB0:
            begin
                if (mem_ack)
                    nxt_s.st = ST_WB1;
            end
            ST_WB1:
            begin
                if (mem_ack)
                    nxt_s.st = ST_WB2;
            end
            ST_WB2:
            begin
                if (mem_ack)
                begin
                    if (chain)
                    begin
                        nxt_s.desc = s_ff.desc + DESC_STRIDE;
                        nxt_s.st = ST_RD0;
                    end
                    else
                    begin
                        nxt_s.st = ST_IDLE;
                        if (s_ff.sw)
                        begin
                            if (fire)
                                nxt_s.swend = 1'b1;
                            else
                                nxt_s.swflag = 1'b0;
                        end
                        else
                        begin
                            nxt_s.ack[s_ff.src] = 1'b1;
                            if (fire)
                            begin
                                // Controller still applies mask and priority
                                nxt_s.pass[s_ff.src] = 1'b1;
                                nxt_s.en[s_ff.src] = 1'b0;
                            end
                        end
                    end
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase
        // Software writes after hardware: a set enable wins over its clear
        if (reg_wr)
        begin
            case (reg_addr)
                REG_SWVEC:
                begin
                    nxt_s.vec = reg_wdata[6:0];
                    nxt_s.swflag = reg_wdata[SWV_FLAG];
                    if (!reg_wdata[SWV_FLAG] && !(s_ff.st == ST_WB2 && mem_ack && s_ff.sw && !chain && fire))
                        nxt_s.swend = 1'b0;
                end
                REG_ENABLE: nxt_s.en = reg_wdata[NUM_SRC-1:0];
                default: nxt_s.en = nxt_s.en;
            endcase
        end
        // Bus request follows the state about to be entered
        nxt_s.mem = '0;
        nxt_s.mem.req = nxt_s.st != ST_IDLE;
        nxt_s.mem.size = SIZE_LONG;
        case (nxt_s.st)
            ST_VEC:
            begin
                nxt_s.mem.addr = nxt_s.desc;
                nxt_s.mem.size = SIZE_WORD;
            end
            ST_RD0: nxt_s.mem.addr = nxt_s.desc;
            ST_RD1: nxt_s.mem.addr = nxt_s.desc + OFS_WORD1;
            ST_RD2: nxt_s.mem.addr = nxt_s.desc + OFS_WORD2;
            ST_DRD:
            begin
                nxt_s.mem.addr = nxt_s.srca;
                nxt_s.mem.size = nxt_s.mwa[MA_SZ] ? SIZE_WORD : SIZE_BYTE;
            end
            ST_DWR:
            begin
                nxt_s.mem.we = 1'b1;
                nxt_s.mem.addr = nxt_s.dsta;
                nxt_s.mem.size = nxt_s.mwa[MA_SZ] ? SIZE_WORD : SIZE_BYTE;
                nxt_s.mem.wdata = {16'h0000, nxt_s.data};
            end
            ST_WB0:
            begin
                nxt_s.mem.we = 1'b1;
                nxt_s.mem.addr = nxt_s.desc;
                nxt_s.mem.wdata = {nxt_s.mwa, nxt_s.srca};
            end
            ST_WB1:
            begin
                nxt_s.mem.we = 1'b1;
                nxt_s.mem.addr = nxt_s.desc + OFS_WORD1;
                nxt_s.mem.wdata = {nxt_s.mwb, nxt_s.dsta};
            end
            ST_WB2:
            begin
                nxt_s.mem.we = 1'b1;
                nxt_s.mem.addr = nxt_s.desc + OFS_WORD2;
                nxt_s.mem.wdata = {nxt_s.cnta, nxt_s.cntb};
            end
            default: nxt_s.mem.addr = 24'h000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign reg_rdata = s_ff.rdata;
    assign act_ack = s_ff.ack;
    assign src_irq_pass = s_ff.pass;
    assign software_transfer_end_irq = s_ff.swend;
    assign mem_out = s_ff.mem;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic wb_end;
    assign wb_end = s_ff.st == ST_WB2 && mem_ack;

    chk_sw_vector: assert property ((s_ff.st == ST_IDLE && s_ff.swflag && !s_ff.swend) |=>
        (mem_out.addr == VEC_BASE + {16'h0000, $past(s_ff.vec), 1'b0} && mem_out.size == SIZE_WORD))
        else $error("software vector address wrong");
    chk_desc_order: assert property ((s_ff.st == ST_RD0 && mem_ack) |=>
        (s_ff.st == ST_RD1 && mem_out.addr == $past(s_ff.desc) + OFS_WORD1))
        else $error("descriptor read order wrong");
    chk_write_back: assert property ((s_ff.st == ST_DWR && mem_ack && md != MD_BLOCK) |=>
        (s_ff.st == ST_WB0 && mem_out.we && mem_out.addr == s_ff.desc))
        else $error("descriptor not written back");
    chk_chain_next: assert property ((wb_end && chain) |=>
        (s_ff.st == ST_RD0 && mem_out.addr == $past(s_ff.desc) + DESC_STRIDE))
        else $error("chain did not fetch next descriptor");
    chk_chain_quiet: assert property ((wb_end && chain) |=>
        (src_irq_pass == '0 && act_ack == '0 && $stable(s_ff.swflag)))
        else $error("chained descriptor disturbed interrupts");
    chk_repeat_quiet: assert property ((wb_end && !chain && md == MD_REPEAT && !s_ff.mwb[MB_IRQSEL]) |=>
        (src_irq_pass == '0 && !$rose(software_transfer_end_irq)))
        else $error("repeat mode raised an interrupt");
    chk_sw_hold: assert property ((wb_end && !chain && s_ff.sw && fire) |=>
        (s_ff.swflag && software_transfer_end_irq))
        else $error("software end not raised");
    chk_sw_clear: assert property ((wb_end && !chain && s_ff.sw && !fire && !reg_wr) |=>
        (!s_ff.swflag && !software_transfer_end_irq))
        else $error("software flag not cleared");
    chk_sw_busy: assert property ((s_ff.st != ST_IDLE && s_ff.sw) |-> !software_transfer_end_irq)
        else $error("software end raised while busy");
    chk_enable_drop: assert property ((wb_end && !chain && !s_ff.sw && fire && !reg_wr) |=>
        (src_irq_pass != '0 && (s_ff.en & src_irq_pass) == '0))
        else $error("source enable not cleared");

    cov_block_loop: cover property (s_ff.st == ST_DWR && mem_ack && md == MD_BLOCK ##1 s_ff.st == ST_DRD);
    cov_chain: cover property (wb_end && chain);
    cov_sw_end: cover property ($rose(software_transfer_end_irq));
    cov_hw_pass: cover property (src_irq_pass != '0);

endmodule

/* common/idte_pkg.sv */
// Overview of operation
// - Each activation reads the descriptor from RAM, transfers, then writes it back.
// - Source and destination address words are 24 bits wide.
// - After each transfer both addresses independently increment, decrement or hold.
// - Normal mode moves one unit per activation; count A counts 1 to 65,536.
// - Normal mode may request a CPU interrupt once count A completes.
// - Repeat mode: high count byte holds 1 to 256, low byte counts transfers.
// - Repeat mode reloads counter and repeat-area address when exhausted, then continues; the code restores the address read at this activation's start.
// - Repeat mode never completes; no interrupt unless per-transfer select is set.
// - Block mode moves one whole block; source or destination is the block area.
// - Block mode: high count byte holds block size, low byte counts units.
// - Block end restores size counter and block-area address; other address keeps stepping.
// - Block mode count B counts blocks 1 to 65,536; completion requests interrupt.
// - Activation first reads the start address from the source's vector entry.
// - While chain enable is set, the next descriptor follows directly and transfers again.
// - Chained descriptors raise no interrupt and leave the source flag untouched.
// - On completion or per-transfer select, the activating source interrupt proceeds.
// - Passed interrupts stay subject to the interrupt controller's mask and priority.
// - Software activation can end with the software transfer end interrupt.
// - Software transfer with select set or completed keeps the flag and raises end.
// - No software end interrupt while a software transfer waits or runs.
// - Software vector address is H'0400 plus twice the seven-bit vector number.
// - Descriptor order: mode A, source, mode B, destination, count A, count B.
// - Interrupt activation clears the source activation enable when interrupt is requested.
// - Software transfer without select or completion clears the software activate flag.
package idte_pkg;

    // ****************************************************
    // Memory side
    // ****************************************************
    localparam int ADDR_W = 24;
    localparam logic [23:0] VEC_BASE = 24'h000400;
    localparam logic [6:0] SRC_VEC_FIRST = 7'h10;
    localparam logic [7:0] DESC_PAGE = 8'hff;
    localparam logic [23:0] DESC_STRIDE = 24'h00000c;
    localparam logic [23:0] OFS_WORD1 = 24'h000004;
    localparam logic [23:0] OFS_WORD2 = 24'h000008;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } idte_mem_req_t;

    // ****************************************************
    // Mode word fields
    // ****************************************************
    localparam int MA_SM_HI = 7;
    localparam int MA_SM_LO = 6;
    localparam int MA_DM_HI = 5;
    localparam int MA_DM_LO = 4;
    localparam int MA_MD_HI = 3;
    localparam int MA_MD_LO = 2;
    localparam int MA_AREA = 1;
    localparam int MA_SZ = 0;
    localparam int MB_CHAIN = 7;
    localparam int MB_IRQSEL = 6;
    localparam logic [1:0] MD_NORMAL = 2'h0;
    localparam logic [1:0] MD_REPEAT = 2'h1;
    localparam logic [1:0] MD_BLOCK = 2'h2;
    localparam logic [1:0] AM_INC = 2'h2;
    localparam logic [1:0] AM_DEC = 2'h3;

    // ****************************************************
    // Register port and state encoding
    // ****************************************************
    localparam logic [3:0] REG_SWVEC = 4'h0;
    localparam logic [3:0] REG_ENABLE = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam int SWV_FLAG = 7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_VEC = 4'h1,
        ST_RD0 = 4'h3,
        ST_RD1 = 4'h2,
        ST_RD2 = 4'h6,
        ST_DRD = 4'h7,
        ST_DWR = 4'h5,
        ST_WB0 = 4'h4,
        ST_WB1 = 4'hc,
        ST_WB2 = 4'hd
    } idte_state_t;

endpackage

/* tb/idte_mem_model.sv */
module idte_mem_model
(
    input wire logic clk,
    input idte_pkg::idte_mem_req_t mem_out,
    input wire logic [1:0] lag,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import idte_pkg::*;

    // ****************************************
    // On-chip memory with variable wait
    // ****************************************
    logic [7:0] mem [logic [23:0]];
    logic [1:0] wait_cnt = 2'h0;
    logic [31:0] word;

    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0f0f0f0f;

    // Read data toggles outside the ack cycle so a stale sample never matches
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_out.req === 1'b1 && !mem_ack)
        begin
            if (wait_cnt < lag)
            begin
                wait_cnt <= wait_cnt + 2'h1;
            end
            else
            begin
                wait_cnt <= 2'h0;
                mem_ack <= 1'b1;
                for (int k = 0; k < 4; k++)
                begin
                    if (mem_out.we && k < (1 << mem_out.size))
                        mem[mem_out.addr + 24'(k)] = mem_out.wdata[8*k +: 8];
                    word[8*k +: 8] = mem.exists(mem_out.addr + 24'(k)) ? mem[mem_out.addr + 24'(k)] : 8'h5a;
                end
                if (!mem_out.we)
                    mem_rdata <= word;
            end
        end
    end
endmodule

/* tb/interrupt_driven_transfer_engine_test.sv */
module interrupt_driven_transfer_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    import idte_pkg::*;

    // ****************************************
    // Stimulus and checking
    // ****************************************
    localparam logic [23:0] D0 = 24'hffec00;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] act_req = 4'h0;
    logic [3:0] act_ack;
    logic [3:0] src_irq_pass;
    logic software_transfer_end_irq;
    idte_mem_req_t mem_out;
    logic [31:0] mem_rdata;
    logic mem_ack;
    logic [1:0] lag = 2'h0;
    integer seed = 32'h1e7665dd;
    int n_fail = 0;
    int checked = 0;
    logic [7:0] b;
    logic [15:0] w;

    always #20 clk = ~clk;

    idte_engine #(.NUM_SRC(4)) u_idte_engine (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_req(act_req),
        .act_ack(act_ack), .src_irq_pass(src_irq_pass), .software_transfer_end_irq(software_transfer_end_irq),
        .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    idte_mem_model u_idte_mem_model (.clk(clk), .mem_out(mem_out), .lag(lag), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick;
        reg_wr <= 1'b0;
        tick;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick;
        reg_rd <= 1'b0;
        d = reg_rdata;
        tick;
    endtask

    task automatic poke(input logic [23:0] a, input logic [31:0] d);
        for (int k = 0; k < 4; k++)
            u_idte_mem_model.mem[a + 24'(k)] = d[8*k +: 8];
    endtask

    function automatic logic [31:0] peek(input logic [23:0] a);
        for (int k = 0; k < 4; k++)
            peek[8*k +: 8] = u_idte_mem_model.mem[a + 24'(k)];
    endfunction

    function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] m, input logic sz);
        step = (m == AM_INC) ? a + {22'h0, sz, !sz} : (m == AM_DEC) ? a - {22'h0, sz, !sz} : a;
    endfunction

    task automatic desc(input logic [23:0] d, input logic [31:0] l0, input logic [31:0] l1, input logic [31:0] l2);
        poke(d, l0);
        poke(d + 24'h4, l1);
        poke(d + 24'h8, l2);
    endtask

    task automatic wb(input logic [23:0] d, input logic [31:0] l0, input logic [31:0] l1, input logic [31:0] l2);
        check("desc word 0", peek(d), l0);
        check("desc word 1", peek(d + 24'h4), l1);
        check("desc word 2", peek(d + 24'h8), l2);
    endtask

    task automatic hw(input int i, input logic pass);
        int n = 0;
        lag <= 2'($unsigned($random(seed)) % 3);
        act_req[i] <= 1'b1;
        while (act_ack[i] !== 1'b1 && n < 600)
        begin
            tick;
            n++;
        end
        check("source irq pass", src_irq_pass[i], pass);
        check("activation ends", n < 600, 1);
        act_req[i] <= 1'b0;
        tick;
    endtask

    task automatic sw(input logic [6:0] v);
        int n = 0;
        logic [7:0] s;
        lag <= 2'($unsigned($random(seed)) % 3);
        wr(REG_SWVEC, {1'b1, v});
        do
        begin
            rd(REG_STATUS, s);
            n++;
            if (s[0] === 1'b1)
                check("end irq while busy", s[1], 1'b0);
        end while (s[0] !== 1'b0 && n < 200);
        check("software run ends", n < 200, 1);
    endtask

    initial
    begin
        #400000;
        n_fail++;
        wrap_up;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        tick;
        for (int a = 0; a < 4; a++)
        begin
            rd(4'(a), b);
            check("reset value", b, 8'h00);
        end
        wr(4'h9, 8'hff);
        rd(4'h9, b);
        check("unmapped", b, 8'h00);
        wr(REG_ENABLE, 8'h0f);
        poke(24'h000420, 32'hec20ec00);
        poke(24'h000424, 32'hec60ec40);
        b = 8'($random(seed));
        poke(24'hc01000, {24'h0, b});
        desc(D0, 32'hb0c01000, 32'h00802010, 32'h00011234);
        hw(0, 1'b1);
        check("normal byte", peek(24'h802010) & 32'hff, {24'h0, b});
        wb(D0, {8'hb0, step(24'hc01000, AM_INC, 1'b0)}, {8'h00, step(24'h802010, AM_DEC, 1'b0)},
            32'h00001234);
        rd(REG_ENABLE, b);
        check("enable cleared", b, 8'h0e);
        // Count zero must run the full range, not stop at once
        w = 16'($random(seed));
        poke(24'h001100, {16'h0, w});
        desc(D0 + 24'h20, 32'h21001100, 32'h00802000, 32'h00005555);
        hw(1, 1'b0);
        check("normal word", peek(24'h802000) & 32'hffff, {16'h0, w});
        wb(D0 + 24'h20, 32'h21001100, {8'h00, step(24'h802000, AM_INC, 1'b1)}, 32'hffff5555);
        rd(REG_ENABLE, b);
        check("enable kept", b, 8'h0e);
        desc(D0, 32'ha4001200, 32'h00002200, 32'h01010000);
        sw(7'h10);
        wb(D0, 32'ha4001201, 32'h00002200, 32'h01010000);
        rd(REG_STATUS, b);
        check("repeat no irq", b, 8'h00);
        check("end irq pin", software_transfer_end_irq, 1'b0);
        rd(REG_SWVEC, b);
        check("flag cleared", b, 8'h10);
        desc(D0, 32'h80001300, 32'h40002300, 32'h00050000);
        sw(7'h10);
        wb(D0, 32'h80001301, 32'h40002300, 32'h00040000);
        rd(REG_STATUS, b);
        check("end irq", b, 8'h02);
        check("end irq pin", software_transfer_end_irq, 1'b1);
        rd(REG_SWVEC, b);
        check("flag kept", b, 8'h90);
        wr(REG_SWVEC, 8'h10);
        rd(REG_STATUS, b);
        check("end irq cleared", b, 8'h00);
        check("end irq pin", software_transfer_end_irq, 1'b0);
        w = 16'($random(seed));
        poke(24'h001400, {16'h0, w});
        desc(D0 + 24'h40, 32'haa001400, 32'h00002400, 32'h02020001);
        hw(2, 1'b1);
        check("block data", peek(24'h002400) & 32'hffff, {16'h0, w});
        wb(D0 + 24'h40, 32'haa001400, 32'h00002402, 32'h02020000);
        desc(D0 + 24'h60, 32'h80001500, 32'hc0002500, 32'h00010000);
        desc(D0 + 24'h6c, 32'h80001600, 32'h00002600, 32'h00020000);
        hw(3, 1'b0);
        wb(D0 + 24'h60, 32'h80001501, 32'hc0002500, 32'h00000000);
        wb(D0 + 24'h6c, 32'h80001601, 32'h00002600, 32'h00010000);
        rd(REG_ENABLE, b);
        check("chain enable kept", b, 8'h0a);
        wrap_up;
    end
endmodule
